// File: design/pst_decode.sv
`timescale 1ns/1ps
// decodes the selected timing set into wait counts
module pst_decode (
  input  wire logic [15:0] i_timing,      // card_strobe_timing contents
  input  wire logic        i_type_sel,    // access_type_select
  output logic      [5:0]  o_extra,       // low-speed extra waits
  output logic      [3:0]  o_setup,       // address to strobe waits
  output logic      [3:0]  o_hold         // address hold waits
);

  logic [1:0] extra_code;
  logic [2:0] setup_code;
  logic [2:0] hold_code;

  // ---------------------------------------------------------------------------
  // step tables
  // ---------------------------------------------------------------------------
  function automatic logic [3:0] step_waits(input logic [2:0] code);
    logic [3:0] w;
    w = 4'h0;
    case (code)
      3'h0: w = 4'h0;
      3'h1: w = 4'h1;
      3'h2: w = 4'h2;
      3'h3: w = 4'h3;
      3'h4: w = pst_pkg::STEP_W4;
      3'h5: w = pst_pkg::STEP_W5;
      3'h6: w = pst_pkg::STEP_W6;
      default: w = pst_pkg::STEP_W7;
    endcase
    return w;
  endfunction : step_waits

  // set 0 when select is low, set 1 when high
  always_comb begin
    if (i_type_sel) begin
      extra_code = i_timing[pst_pkg::SET1_EXTRA_LSB +: 2];
      setup_code = i_timing[pst_pkg::SET1_ASSERT_LSB +: 3];
      hold_code  = i_timing[pst_pkg::SET1_HOLD_LSB +: 3];
    end else begin
      extra_code = i_timing[pst_pkg::SET0_EXTRA_LSB +: 2];
      setup_code = i_timing[pst_pkg::SET0_ASSERT_LSB +: 3];
      hold_code  = i_timing[pst_pkg::SET0_HOLD_LSB +: 3];
    end
  end

  always_comb begin
    case (extra_code)
      2'h0: o_extra = 6'h00;
      2'h1: o_extra = pst_pkg::EXTRA_W1;
      2'h2: o_extra = pst_pkg::EXTRA_W2;
      default: o_extra = pst_pkg::EXTRA_W3;
    endcase
    o_setup = step_waits(setup_code);
    o_hold  = step_waits(hold_code);
  end

endmodule : pst_decode

// File: design/pst_pkg.sv
package pst_pkg;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [3:0]  ADDR_TIMING   = 4'h0;  // card_strobe_timing
  localparam logic [3:0]  ADDR_WAITCTL  = 4'h4;  // strobe width count (wait_control_second)
  localparam logic [3:0]  ADDR_STATUS   = 4'h8;  // engine state, read only
  localparam logic [15:0] TIMING_RESET  = 16'h0000;
  localparam logic [3:0]  WAITCTL_RESET = 4'h0;

  // ---------------------------------------------------------------------------
  // field positions of card_strobe_timing
  // ---------------------------------------------------------------------------
  localparam int SET0_EXTRA_LSB  = 14;
  localparam int SET1_EXTRA_LSB  = 12;
  localparam int SET0_ASSERT_LSB = 9;
  localparam int SET1_ASSERT_LSB = 6;
  localparam int SET0_HOLD_LSB   = 3;
  localparam int SET1_HOLD_LSB   = 0;

  // ---------------------------------------------------------------------------
  // wait counts
  // ---------------------------------------------------------------------------
  localparam logic [5:0] EXTRA_W1 = 6'h0f;   // 15
  localparam logic [5:0] EXTRA_W2 = 6'h1e;   // 30
  localparam logic [5:0] EXTRA_W3 = 6'h32;   // 50
  localparam logic [3:0] STEP_W4  = 4'h6;
  localparam logic [3:0] STEP_W5  = 4'h9;
  localparam logic [3:0] STEP_W6  = 4'hc;
  localparam logic [3:0] STEP_W7  = 4'hf;

  // access engine states, one-hot
  typedef enum logic [3:0] {
    PST_IDLE   = 4'h1,
    PST_SETUP  = 4'h2,
    PST_STROBE = 4'h4,
    PST_HOLD   = 4'h8
  } pst_state_t;

endpackage : pst_pkg

// File: design/pst_strobe_timing.sv
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Operation
// - 16-bit read/write timing register
// - timing used only for areas 5 and 6
// - power-on clears; manual reset keeps contents
// - strobe width from wait-control register
// - bits 15:14 extra waits, select 0
// - bits 13:12 extra waits, select 1
// - bits 11:9 assert delay, select 0
// - bits 8:6 assert delay, select 1
// - bits 5:3 address hold, select 0
// - bits 2:0 address hold, select 1
// - memory read hold counts from sampling
module pst_strobe_timing (
  input  wire logic        i_clock,        // bus clock, 200 MHz
  input  wire logic        i_reset,        // power-on reset, sync, high
  input  wire logic        i_manual_reset, // manual reset or standby, register kept
  input  wire logic [3:0]  i_addr,         // register byte address
  input  wire logic [15:0] i_wdata,        // register write data
  input  wire logic        i_wr,           // register write strobe
  input  wire logic        i_rd,           // register read strobe
  output logic      [15:0] o_rdata,        // read data, cycle after i_rd
  input  wire logic        i_start,        // access request pulse
  input  wire logic [2:0]  i_area,         // target memory area
  input  wire logic        i_write,        // 1 write, 0 read
  input  wire logic        i_io_card,      // 1 i/o card, 0 memory card
  input  wire logic        i_low_speed,    // low-speed wait cycle
  input  wire logic        i_type_sel,     // access_type_select
  output logic             o_addr_valid,   // address driven to card
  output logic             o_oe_n,         // output enable, low active
  output logic             o_we_n,         // write enable, low active
  output logic             o_sample,       // read data sampling point
  output logic             o_busy,         // access in progress
  output logic             o_done          // access finished pulse
);

  localparam logic [2:0] AREA_A = 3'h5;
  localparam logic [2:0] AREA_B = 3'h6;

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  logic [15:0]            timing;
  logic [3:0]             wait_ctl;
  pst_pkg::pst_state_t    state;
  pst_pkg::pst_state_t    next_state;
  logic [6:0]             count;
  logic [6:0]             next_count;
  logic                   cur_write;
  logic                   cur_io;
  logic                   cur_sel;
  logic [5:0]             dec_extra;
  logic [3:0]             dec_setup;
  logic [3:0]             dec_hold;
  logic [6:0]             strobe_len;
  logic                   is_card;
  logic                   dec_sel;

  // only areas 5 and 6 start a card access
  assign is_card = (i_area == AREA_A) || (i_area == AREA_B);

  // manual reset deliberately not in this process
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      timing <= pst_pkg::TIMING_RESET;
    end else if (i_wr && i_addr == pst_pkg::ADDR_TIMING) begin
      timing <= i_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      wait_ctl <= pst_pkg::WAITCTL_RESET;
    end else if (i_wr && i_addr == pst_pkg::ADDR_WAITCTL) begin
      wait_ctl <= i_wdata[3:0];
    end
  end

  // unmapped reads return zero
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        pst_pkg::ADDR_TIMING:  o_rdata <= timing;
        pst_pkg::ADDR_WAITCTL: o_rdata <= {12'h000, wait_ctl};
        pst_pkg::ADDR_STATUS:  o_rdata <= {12'h000, state};
        default:               o_rdata <= 16'h0000;
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------------------
  // access engine
  // ---------------------------------------------------------------------------
  // while idle the request's own select picks the set, so the setup count loaded at
  // the start edge matches the access; after that the latched copy keeps it steady
  assign dec_sel = (state == pst_pkg::PST_IDLE) ? i_type_sel : cur_sel;

  pst_decode u_decode (
    .i_timing   (timing),
    .i_type_sel (dec_sel),
    .o_extra    (dec_extra),
    .o_setup    (dec_setup),
    .o_hold     (dec_hold)
  );

  // strobe width: base cycle plus wait control, plus extra only when low speed
  assign strobe_len = 7'(wait_ctl) + (i_low_speed ? 7'(dec_extra) : 7'h00);

  // count holds waits left in the current phase, one per clock
  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      pst_pkg::PST_IDLE: begin
        if (i_start && is_card) begin
          next_state = pst_pkg::PST_SETUP;
          next_count = 7'(dec_setup);
        end
      end
      pst_pkg::PST_SETUP: begin
        if (count == 7'h00) begin
          next_state = pst_pkg::PST_STROBE;
          next_count = strobe_len;
        end else begin
          next_count = count - 7'h01;
        end
      end
      pst_pkg::PST_STROBE: begin
        if (count == 7'h00) begin
          next_state = pst_pkg::PST_HOLD;
          next_count = 7'(dec_hold);
        end else begin
          next_count = count - 7'h01;
        end
      end
      pst_pkg::PST_HOLD: begin
        if (count == 7'h00) begin
          next_state = pst_pkg::PST_IDLE;
        end else begin
          next_count = count - 7'h01;
        end
      end
      default: begin
        next_state = pst_pkg::PST_IDLE;
        next_count = 7'h00;
      end
    endcase
  end

  // manual reset aborts the access but keeps the register
  always_ff @(posedge i_clock) begin
    if (i_reset || i_manual_reset) begin
      state <= pst_pkg::PST_IDLE;
      count <= 7'h00;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // latch request attributes so the set cannot change mid-access
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cur_write <= 1'b0;
      cur_io    <= 1'b0;
      cur_sel   <= 1'b0;
    end else if (state == pst_pkg::PST_IDLE) begin
      cur_write <= i_write;
      cur_io    <= i_io_card;
      cur_sel   <= i_type_sel;
    end
  end

  // ---------------------------------------------------------------------------
  // card pins
  // ---------------------------------------------------------------------------
  // memory read drops the strobe at sampling; hold then counts from that point
  always_ff @(posedge i_clock) begin
    if (i_reset || i_manual_reset) begin
      o_addr_valid <= 1'b0;
      o_oe_n       <= 1'b1;
      o_we_n       <= 1'b1;
      o_sample     <= 1'b0;
      o_busy       <= 1'b0;
      o_done       <= 1'b0;
    end else begin
      o_addr_valid <= (next_state != pst_pkg::PST_IDLE);
      o_oe_n       <= !(next_state == pst_pkg::PST_STROBE && !cur_write);
      o_we_n       <= !(next_state == pst_pkg::PST_STROBE && cur_write);
      o_sample     <= (state == pst_pkg::PST_STROBE) && (count == 7'h00) && !cur_write;
      o_busy       <= (next_state != pst_pkg::PST_IDLE);
      o_done       <= (state == pst_pkg::PST_HOLD) && (count == 7'h00);
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_reg_write_read: assert property (@(posedge i_clock) disable iff (i_reset)
    (i_wr && i_addr == pst_pkg::ADDR_TIMING) ##1 (i_rd && i_addr == pst_pkg::ADDR_TIMING && !i_wr)
      |=> o_rdata == $past(i_wdata, 2))
    else $error("timing register readback mismatch");

  a_area_only: assert property (@(posedge i_clock) disable iff (i_reset)
    (state == pst_pkg::PST_IDLE && i_start && !is_card && !i_manual_reset) |=> !o_busy)
    else $error("access started outside card areas");

  a_poweron_clear: assert property (@(posedge i_clock)
    i_reset |=> timing == 16'h0000)
    else $error("power-on reset did not clear timing");

  a_manual_keep: assert property (@(posedge i_clock) disable iff (i_reset)
    (i_manual_reset && !i_wr) |=> $stable(timing))
    else $error("manual reset disturbed timing");

  a_strobe_width: assert property (@(posedge i_clock) disable iff (i_reset || i_manual_reset)
    (state == pst_pkg::PST_SETUP && count == 7'h00) |=> count == $past(strobe_len))
    else $error("strobe width not from wait control");

  a_setup_load: assert property (@(posedge i_clock) disable iff (i_reset || i_manual_reset)
    (state == pst_pkg::PST_IDLE && i_start && is_card) |=> count == $past(7'(dec_setup)))
    else $error("setup count wrong");

  a_hold_load: assert property (@(posedge i_clock) disable iff (i_reset || i_manual_reset)
    (state == pst_pkg::PST_STROBE && count == 7'h00) |=> state == pst_pkg::PST_HOLD && count == $past(7'(dec_hold)))
    else $error("hold count wrong");

  a_wait_step: assert property (@(posedge i_clock) disable iff (i_reset || i_manual_reset)
    (state != pst_pkg::PST_IDLE && count != 7'h00) |=> count == $past(count) - 7'h01)
    else $error("wait not one clock");

  a_sample_hold: assert property (@(posedge i_clock) disable iff (i_reset || i_manual_reset)
    o_sample |-> state == pst_pkg::PST_HOLD && o_oe_n)
    else $error("sampling not at start of hold");

  a_extra_sel: assert property (@(posedge i_clock) disable iff (i_reset)
    (dec_sel && timing[pst_pkg::SET1_EXTRA_LSB +: 2] == 2'h3) |-> dec_extra == pst_pkg::EXTRA_W3)
    else $error("extra wait select wrong");

  // ---------------------------------------------------------------------------
  // checks on the card pins, the registers and their port, and the latched request
  // ---------------------------------------------------------------------------
  // an accepted start shows on the pins at once
  a_busy_rise: assert property (@(posedge i_clock) disable iff (i_reset)
    (state == pst_pkg::PST_IDLE && i_start && is_card && !i_manual_reset) |=> o_busy && o_addr_valid)
    else $error("accepted start not shown on pins");

  a_idle_pins: assert property (@(posedge i_clock) disable iff (i_reset)
    (state == pst_pkg::PST_IDLE) |-> !o_addr_valid && !o_busy && o_oe_n && o_we_n)
    else $error("card pins active while idle");

  a_setup_quiet: assert property (@(posedge i_clock) disable iff (i_reset)
    (state == pst_pkg::PST_SETUP) |-> o_addr_valid && o_oe_n && o_we_n)
    else $error("strobe asserted during address setup");

  // both strobes low at once would let the card and the device fight over the data bus
  a_strobe_excl: assert property (@(posedge i_clock) disable iff (i_reset)
    !(!o_oe_n && !o_we_n))
    else $error("both strobes asserted");

  a_strobe_addr: assert property (@(posedge i_clock) disable iff (i_reset)
    (!o_oe_n || !o_we_n) |-> o_addr_valid)
    else $error("strobe without address");

  a_strobe_enter: assert property (@(posedge i_clock) disable iff (i_reset || i_manual_reset)
    (state == pst_pkg::PST_SETUP && count == 7'h00) |=> (cur_write ? (!o_we_n && o_oe_n) : (!o_oe_n && o_we_n)))
    else $error("wrong strobe after setup");

  a_hold_release: assert property (@(posedge i_clock) disable iff (i_reset || i_manual_reset)
    (state == pst_pkg::PST_STROBE && count == 7'h00) |=> o_oe_n && o_we_n && o_addr_valid)
    else $error("address not held after strobe");

  a_sample_read: assert property (@(posedge i_clock) disable iff (i_reset || i_manual_reset)
    o_sample |-> !cur_write)
    else $error("sampling pulse in a write");

  a_done_pulse: assert property (@(posedge i_clock) disable iff (i_reset || i_manual_reset)
    o_done |=> !o_done)
    else $error("done longer than one cycle");

  a_done_idle: assert property (@(posedge i_clock) disable iff (i_reset)
    o_done |-> !o_busy && !o_addr_valid && o_oe_n && o_we_n)
    else $error("pins active with done");

  // the set in use may not change under a running access
  a_attr_steady: assert property (@(posedge i_clock) disable iff (i_reset)
    (state != pst_pkg::PST_IDLE) |=> $stable(cur_sel) && $stable(cur_write))
    else $error("request attributes changed mid-access");

  a_waitctl_keep: assert property (@(posedge i_clock) disable iff (i_reset)
    (i_manual_reset && !i_wr) |=> $stable(wait_ctl))
    else $error("manual reset disturbed wait control");

  // read data stand for one cycle only, so a stale word never looks like an answer
  a_rdata_idle: assert property (@(posedge i_clock) disable iff (i_reset)
    !i_rd |=> o_rdata == 16'h0000)
    else $error("read data outside read cycle");

  a_unmapped_read: assert property (@(posedge i_clock) disable iff (i_reset)
    (i_rd && i_addr != pst_pkg::ADDR_TIMING && i_addr != pst_pkg::ADDR_WAITCTL && i_addr != pst_pkg::ADDR_STATUS)
      |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");

endmodule : pst_strobe_timing

// File: dv/pst_card_model.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// card side: measures each strobe phase that reaches the card
// -----------------------------------------------------------------------------
module pst_card_model (
  input  wire logic       i_clock,      // bus clock
  input  wire logic       i_addr_valid, // address driven to the card
  input  wire logic       i_oe_n,       // output enable, low active
  input  wire logic       i_we_n,       // write enable, low active
  input  wire logic       i_sample,     // read sampling point
  output logic      [7:0] o_setup,      // cycles of address before strobe
  output logic      [7:0] o_strobe,     // cycles of strobe low
  output logic      [7:0] o_hold,       // cycles of address after strobe
  output logic      [1:0] o_samples,    // sampling pulses in one access
  output logic            o_wrote       // write enable seen low
);
  logic av_q = 1'b0;
  logic seen;

  // counts restart when a new address appears, so results stand after the access
  always_ff @(posedge i_clock) begin
    av_q <= i_addr_valid;
    if (i_addr_valid && !av_q) begin
      o_setup   <= 8'h01;
      o_strobe  <= 8'h00;
      o_hold    <= 8'h00;
      o_samples <= 2'h0;
      o_wrote   <= 1'b0;
      seen      <= 1'b0;
    end else if (i_addr_valid) begin
      // one bus clock per wait, whichever phase it lands
      if (!i_oe_n || !i_we_n) begin
        o_strobe <= o_strobe + 8'h01;
        seen     <= 1'b1;
      end else if (seen) begin
        o_hold <= o_hold + 8'h01;
      end else begin
        o_setup <= o_setup + 8'h01;
      end
      if (!i_we_n) begin
        o_wrote <= 1'b1;
      end
      if (i_sample) begin
        o_samples <= o_samples + 2'h1;
      end
    end
  end
endmodule : pst_card_model

// File: dv/pst_strobe_timing_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module pst_strobe_timing_tb;
  localparam logic [7:0] STEPS [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h09, 8'h0c, 8'h0f};
  localparam logic [7:0] EXTRAS [4] = '{8'h00, 8'h0f, 8'h1e, 8'h32};
  logic        i_clock = 1'b0, i_reset = 1'b1, i_manual_reset = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000, o_rdata, tv;
  logic        i_wr = 1'b0, i_rd = 1'b0, i_start = 1'b0, i_write = 1'b0, i_io_card = 1'b0;
  logic [2:0]  i_area = 3'h0, kk;
  logic        i_low_speed = 1'b0, i_type_sel = 1'b0, low, sel;
  logic        o_addr_valid, o_oe_n, o_we_n, o_sample, o_busy, o_done, wrote;
  logic [7:0]  m_setup, m_strobe, m_hold;
  logic [1:0]  m_samples;
  int          err_total = 0, n_compared = 0, cycles = 0;

  always #2.5 i_clock = ~i_clock;

  pst_strobe_timing pst_strobe_timing_i (.i_clock(i_clock), .i_reset(i_reset), .i_manual_reset(i_manual_reset),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_start(i_start),
    .i_area(i_area), .i_write(i_write), .i_io_card(i_io_card), .i_low_speed(i_low_speed),
    .i_type_sel(i_type_sel), .o_addr_valid(o_addr_valid), .o_oe_n(o_oe_n), .o_we_n(o_we_n),
    .o_sample(o_sample), .o_busy(o_busy), .o_done(o_done));

  pst_card_model pst_card_model_i (.i_clock(i_clock), .i_addr_valid(o_addr_valid), .i_oe_n(o_oe_n),
    .i_we_n(o_we_n), .i_sample(o_sample), .o_setup(m_setup), .o_strobe(m_strobe), .o_hold(m_hold),
    .o_samples(m_samples), .o_wrote(wrote));

  // -----------------------------------------------------------------------------
  // closing report and hang guard
  // -----------------------------------------------------------------------------
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  // the whole run is under a thousand cycles, so this only trips on a hang
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  // -----------------------------------------------------------------------------
  // register bus and access tasks
  // -----------------------------------------------------------------------------
  // called right after a rising edge; strobes may follow each other with no gap
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe: taken at the edge closing it
  task automatic rd(input logic [3:0] a, input logic [15:0] ex);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(posedge i_clock);
    `CHK("rdata", ex, o_rdata)
  endtask : rd

  // a second start while busy must be ignored and leave the phases as they were
  task automatic acc(input logic s, w, io, lo, input logic [7:0] es, ew, eh);
    int t;
    @(posedge i_clock);
    i_start <= 1'b1;
    i_type_sel <= s;
    i_area <= 3'h5 + {2'h0, s};
    i_write <= w;
    i_io_card <= io;
    i_low_speed <= lo;
    @(posedge i_clock);
    i_start <= 1'b0;
    @(posedge i_clock);
    i_start <= 1'b1;
    @(posedge i_clock);
    i_start <= 1'b0;
    t = 0;
    while (o_done !== 1'b1 && t < 400) begin
      @(posedge i_clock);
      t++;
    end
    `CHK("done", 1'b1, o_done)
    `CHK("busy", 1'b0, o_busy)
    `CHK("setup", es, m_setup)
    `CHK("strobe", ew, m_strobe)
    `CHK("hold", eh, m_hold)
    `CHK("samples", {1'b0, ~w}, m_samples)
    `CHK("wrote", w, wrote)
  endtask : acc

  // -----------------------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
    rd(pst_pkg::ADDR_TIMING, 16'h0000);
    rd(pst_pkg::ADDR_WAITCTL, 16'h0000);
    rd(pst_pkg::ADDR_STATUS, {12'h000, pst_pkg::PST_IDLE});
    wr(4'hc, 16'hffff);
    rd(4'hc, 16'h0000);
    rd(pst_pkg::ADDR_TIMING, 16'h0000);
    // every field code of both sets, each set taken in turn by the select
    for (int k = 0; k < 8; k++) begin
      kk = 3'(k);
      tv = {kk[1:0], ~kk[1:0], kk, ~kk, kk + 3'h3, ~(kk + 3'h3)};
      wr(pst_pkg::ADDR_TIMING, tv);
      rd(pst_pkg::ADDR_TIMING, tv);
      wr(pst_pkg::ADDR_WAITCTL, {12'h000, kk, 1'b1});
      low = (k != 3);
      for (int j = 0; j < 2; j++) begin
        sel = j[0];
        acc(sel, kk[0] ^ sel, kk[1], low, STEPS[sel ? ~kk : kk] + 8'h01,
            {4'h0, kk, 1'b1} + (low ? EXTRAS[sel ? ~kk[1:0] : kk[1:0]] : 8'h00) + 8'h01,
            STEPS[sel ? ~(kk + 3'h3) : kk + 3'h3] + 8'h01);
      end
    end
    // areas other than 5 and 6 never start an access
    for (int a = 0; a < 8; a++) begin
      if (a == 5 || a == 6) continue;
      @(posedge i_clock);
      i_start <= 1'b1;
      i_area <= 3'(a);
      @(posedge i_clock);
      i_start <= 1'b0;
      repeat (2) @(posedge i_clock);
      `CHK("busy", 1'b0, o_busy)
    end
    // manual reset mid-access drops the pins but keeps the timing register; power-on reset clears it
    @(posedge i_clock);
    i_start <= 1'b1;
    i_area <= 3'h5;
    @(posedge i_clock);
    i_start <= 1'b0;
    i_manual_reset <= 1'b1;
    @(posedge i_clock);
    i_manual_reset <= 1'b0;
    @(posedge i_clock);
    `CHK("busy", 1'b0, o_busy)
    `CHK("addr_valid", 1'b0, o_addr_valid)
    rd(pst_pkg::ADDR_TIMING, tv);
    @(posedge i_clock);
    i_reset <= 1'b1;
    @(posedge i_clock);
    i_reset <= 1'b0;
    rd(pst_pkg::ADDR_TIMING, pst_pkg::TIMING_RESET);
    end_of_test();
  end
endmodule : pst_strobe_timing_tb
